// >>> ars_defs.svh
/*
 Constants of the cold reset sequencer: clock, timing figures, data words.
 Assumes inclusion by bare name from the package and the sequencer.
*/
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH

// =====================================================================
// clock and timing
`define ARS_CLK_PERIOD_NS   40
`define ARS_FLASH_INIT_NS   1000000
`define ARS_EXT_MIN_HALF    3
`define ARS_EXT_MAX_HALF    8
`define ARS_BLANK_CYCLES    16
`define ARS_CNT_W           16
`define ARS_DLY_W           4
`define ARS_CFG_W           16

// =====================================================================
// data words and levels
`define ARS_BLANK_WORD      16'hFFFF
`define ARS_ILLEGAL_OPCODE  16'h009B
`define ARS_RESET_VECTOR    24'h000000
`define ARS_ALE_IDLE        1'b0
`define ARS_STROBE_IDLE_N   1'b1

`endif

// >>> ars_pkg.sv
/*
 Types of the cold reset sequencer: state encoding and the state record.
 Assumes ars_defs.svh is on the include path.
*/
`include "ars_defs.svh"

package ars_pkg;

   // ==================================================================
   // sequence states
   typedef enum logic [1:0] {
      ARS_HOLD       = 2'b00,
      ARS_BOOT_DLY   = 2'b01,
      ARS_FLASH_WAIT = 2'b10,
      ARS_RUN        = 2'b11
   } ars_state_t;

   // ==================================================================
   // whole state of the sequencer
   typedef struct packed {
      ars_state_t                st;
      logic [`ARS_CNT_W-1:0]     fcnt;
      logic                      fl_rdy;
      logic [`ARS_DLY_W-1:0]     dcnt;
      logic                      boot_ext;
      logic                      core_rst_n;
      logic                      drv_off;
      logic [`ARS_CFG_W-1:0]     cfg;
      logic [15:0]               rdata;
      logic                      fetch_go;
   } ars_regs_t;

   localparam ars_regs_t ARS_REGS_RST = '{
      st:         ARS_HOLD,
      fcnt:       '0,
      fl_rdy:     1'b0,
      dcnt:       '0,
      boot_ext:   1'b0,
      core_rst_n: 1'b0,
      drv_off:    1'b1,
      cfg:        '0,
      rdata:      `ARS_BLANK_WORD,
      fetch_go:   1'b0
   };

endpackage : ars_pkg

// >>> ars_sequencer.sv
/*
 Cold (asynchronous) reset sequencer: entry, hold, flash-init or
 external-boot release, configuration latch and restart.
 Assumes a 25 MHz sys_clk that may be absent during entry, a flash
 controller that reports init done, and pins on the caller's pads.
*/
// Notes on behaviour
// - request low with kind select low puts the device in reset.
// - entry drops indicator, cancels holds, aborts cycles, floats pins, pulls config high.
// - entry needs no running clock.
// - internal boot keeps core reset until flash init done, at most 1 ms.
// - external boot releases core reset 3 to 8 half clocks after filtered release.
// - flash reads before init give all ones, later the illegal opcode.
// - exit latches configuration port and drives strobes inactive.
// - fetch restarts at address zero of segment zero.
// - kind select found low or falling low during request means cold reset.
`timescale 1ns/1ps
`include "ars_defs.svh"

module ars_sequencer
   import ars_pkg::*;
#(
   parameter int unsigned FLASH_INIT_CYCLES  = `ARS_FLASH_INIT_NS / `ARS_CLK_PERIOD_NS,
   parameter int unsigned FLASH_BLANK_CYCLES = `ARS_BLANK_CYCLES
) (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   // reset pins
   input  wire logic                  reset_request_n,
   input  wire logic                  reset_kind_select,
   input  wire logic                  external_boot_select_n,
   input  wire logic [`ARS_CFG_W-1:0] configuration_port,
   // flash
   input  wire logic                  flash_init_done,
   input  wire logic [15:0]           flash_array_data,
   output logic      [15:0]           flash_read_data_q,
   output logic                       flash_ready,
   // reset outputs
   output logic                       reset_indicator_n,
   output logic                       core_reset_n,
   output logic                       hold_cancel,
   output logic                       bus_abort,
   // pin drivers, enables low while driving
   output logic                       bus_oe_n,
   output logic                       io_oe_n,
   output logic                       config_pullup,
   output logic                       ctrl_oe_n,
   output logic                       ale,
   output logic                       rd_n,
   output logic                       write_strobe_n,
   // restart
   output logic [`ARS_CFG_W-1:0]      sys_config_q,
   output logic                       fetch_start,
   output logic [23:0]                fetch_addr
);

   // ==================================================================
   // derived timing
   localparam int HALF_NS    = `ARS_CLK_PERIOD_NS / 2;
   // least time rounds up; the synchroniser stands in for the pin filter
   localparam int EXT_CYCLES = (`ARS_EXT_MIN_HALF * HALF_NS + `ARS_CLK_PERIOD_NS - 1)
                               / `ARS_CLK_PERIOD_NS;
   localparam int EXT_MAX    = (`ARS_EXT_MAX_HALF * HALF_NS) / `ARS_CLK_PERIOD_NS;
   localparam logic [`ARS_DLY_W-1:0] DLY_LAST   = `ARS_DLY_W'(EXT_CYCLES - 1);
   localparam logic [`ARS_CNT_W-1:0] FLASH_LAST = `ARS_CNT_W'(FLASH_INIT_CYCLES - 1);
   localparam logic [`ARS_CNT_W-1:0] BLANK_END  = `ARS_CNT_W'(FLASH_BLANK_CYCLES);

   // ==================================================================
   // cold reset entry
   logic arst_n;
   // clockless entry: pins reach the async reset directly, no clock needed
   assign arst_n = rst_b & (reset_request_n | reset_kind_select);

   // ==================================================================
   // pin synchronisers
   logic                  req_s;
   logic                  boot_n_s;
   logic                  done_s;
   logic [`ARS_CFG_W-1:0] cfg_s;

   ars_sync #(
      .W (`ARS_CFG_W + 3)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_b   (arst_n),
      .d       ({reset_request_n, external_boot_select_n, flash_init_done,
                 configuration_port}),
      .q       ({req_s, boot_n_s, done_s, cfg_s})
   );

   // ==================================================================
   // sequence
   ars_regs_t q;
   ars_regs_t n;

   always_comb begin
      n          = q;
      n.fetch_go = 1'b0;
      // flash init runs from request release whatever the boot source
      if (q.st != ARS_HOLD && !q.fl_rdy) begin
         if (done_s || q.fcnt == FLASH_LAST) begin
            n.fl_rdy = 1'b1;
         end else begin
            n.fcnt = q.fcnt + 1'b1;
         end
      end
      if (q.fl_rdy) begin
         n.rdata = flash_array_data;
      end else if (q.fcnt < BLANK_END) begin
         n.rdata = `ARS_BLANK_WORD;
      end else begin
         n.rdata = `ARS_ILLEGAL_OPCODE;
      end
      case (q.st)
         ARS_HOLD: begin
            n.fcnt     = '0;
            n.dcnt     = '0;
            n.fl_rdy   = 1'b0;
            n.boot_ext = ~boot_n_s;
            if (req_s) begin
               n.st = boot_n_s ? ARS_FLASH_WAIT : ARS_BOOT_DLY;
            end
         end
         ARS_BOOT_DLY: begin
            if (!req_s) begin
               n.st = ARS_HOLD;
            end else if (q.dcnt == DLY_LAST) begin
               n.st = ARS_RUN;
            end else begin
               n.dcnt = q.dcnt + 1'b1;
            end
         end
         ARS_FLASH_WAIT: begin
            if (!req_s) begin
               n.st = ARS_HOLD;
            end else if (q.fl_rdy) begin
               n.st = ARS_RUN;
            end
         end
         ARS_RUN: begin
            n.st = ARS_RUN;
         end
         default: begin
            n.st = ARS_HOLD;
         end
      endcase
      // exit: latch config, drive pins, release core and indicator
      if (q.st != ARS_RUN && n.st == ARS_RUN) begin
         n.core_rst_n = 1'b1;
         n.drv_off    = 1'b0;
         n.cfg        = cfg_s;
         n.fetch_go   = 1'b1;
      end
   end

   // entry state: indicator low, drivers off, pull-ups on
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= ARS_REGS_RST;
      end else begin
         q <= n;
      end
   end

   // ==================================================================
   // outputs
   assign reset_indicator_n = q.core_rst_n;
   assign core_reset_n      = q.core_rst_n;
   assign hold_cancel       = q.drv_off;
   assign bus_abort         = q.drv_off;
   assign bus_oe_n          = q.drv_off;
   assign io_oe_n           = q.drv_off;
   assign config_pullup     = q.drv_off;
   assign ctrl_oe_n         = q.drv_off;
   // strobes only ever leave this block idle; the bus unit takes over later
   assign ale               = `ARS_ALE_IDLE;
   assign rd_n              = `ARS_STROBE_IDLE_N;
   assign write_strobe_n    = `ARS_STROBE_IDLE_N;
   assign sys_config_q      = q.cfg;
   assign fetch_start       = q.fetch_go;
   assign fetch_addr        = `ARS_RESET_VECTOR;
   assign flash_read_data_q = q.rdata;
   assign flash_ready       = q.fl_rdy;

   // ==================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence ext_rise_s;
      $rose(req_s) && !boot_n_s && q.st == ARS_HOLD;
   endsequence

   sequence ext_hold_s;
      ext_rise_s ##1 req_s [*2];
   endsequence

   entry_pins_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (!reset_request_n && !reset_kind_select) |->
         !reset_indicator_n && q.st == ARS_HOLD && bus_oe_n)
      else $error("cold reset pins did not force reset state");

   kind_fall_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      ($fell(reset_kind_select) && !reset_request_n) |-> !core_reset_n)
      else $error("kind select falling during request missed");

   float_drivers_a: assert property (
      !core_reset_n |-> bus_oe_n && io_oe_n && config_pullup && hold_cancel)
      else $error("drivers active while core reset held");

   flash_hold_a: assert property (
      ($rose(core_reset_n) && !q.boot_ext) |-> $past(q.fl_rdy) && $past(req_s))
      else $error("core released before flash init done");

   ext_release_a: assert property (
      ext_hold_s |-> !core_reset_n ##1 core_reset_n)
      else $error("external boot release not after delay");

   ext_bound_a: assert property (
      ext_hold_s |-> ##[0:EXT_MAX] core_reset_n)
      else $error("external boot release later than the longest delay");

   flash_word_a: assert property (
      (q.st == ARS_HOLD) |=> flash_read_data_q == `ARS_BLANK_WORD)
      else $error("flash data not blank during reset");

   early_word_a: assert property (
      !$past(q.fl_rdy) |->
         (flash_read_data_q == `ARS_BLANK_WORD ||
          flash_read_data_q == `ARS_ILLEGAL_OPCODE))
      else $error("flash data leaked before init");

   exit_latch_a: assert property (
      $rose(core_reset_n) |->
         sys_config_q == $past(cfg_s) && !ctrl_oe_n && rd_n && write_strobe_n)
      else $error("exit did not latch config or idle strobes");

   restart_vec_a: assert property (
      $rose(core_reset_n) |-> fetch_start && fetch_addr == `ARS_RESET_VECTOR
         ##1 !fetch_start)
      else $error("restart fetch not at vector zero");

   indicator_span_a: assert property (
      (q.st != ARS_RUN) |-> !reset_indicator_n && !core_reset_n)
      else $error("indicator released while core reset held");

endmodule : ars_sequencer

// >>> ars_sequencer_bench.sv
/*
 Self-checking bench of the cold reset sequencer.
 Assumes the supervisor model drives every pin and flash input.
*/
`timescale 1ns/1ps

module ars_sequencer_bench;
   localparam int FL_CYC = 40;
   localparam int LIM    = 200;
   logic        sys_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        clk_run = 1'b1;
   logic        reset_request_n, reset_kind_select, external_boot_select_n;
   logic        flash_init_done, flash_ready, reset_indicator_n, core_reset_n;
   logic        hold_cancel, bus_abort, bus_oe_n, io_oe_n, config_pullup, ctrl_oe_n;
   logic        ale, rd_n, write_strobe_n, fetch_start;
   logic [15:0] configuration_port, flash_array_data, flash_read_data_q, sys_config_q;
   logic [23:0] fetch_addr;
   int          err_total = 0;
   int          n_checks  = 0;

   always #20 if (clk_run) sys_clk = ~sys_clk;

   ars_supervisor i_sup (.sys_clk, .reset_request_n, .reset_kind_select,
      .external_boot_select_n, .configuration_port, .flash_init_done, .flash_array_data);

   ars_sequencer #(.FLASH_INIT_CYCLES(FL_CYC), .FLASH_BLANK_CYCLES(4)) i_dut (
      .sys_clk, .rst_b, .reset_request_n, .reset_kind_select, .external_boot_select_n,
      .configuration_port, .flash_init_done, .flash_array_data, .flash_read_data_q,
      .flash_ready, .reset_indicator_n, .core_reset_n, .hold_cancel, .bus_abort,
      .bus_oe_n, .io_oe_n, .config_pullup, .ctrl_oe_n, .ale, .rd_n, .write_strobe_n,
      .sys_config_q, .fetch_start, .fetch_addr);

   // =====================================================
   // helpers
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("FAIL at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   // 1FB while held, 603 once running
   function automatic logic [23:0] pins();
      return {13'h0, reset_indicator_n, core_reset_n, hold_cancel, bus_abort,
              config_pullup, bus_oe_n, io_oe_n, ctrl_oe_n, ale, rd_n, write_strobe_n};
   endfunction : pins

   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic wait_core(output int n);
      n = 0;
      while (core_reset_n !== 1'b1 && n < LIM) begin
         tick();
         n++;
      end
      if (n >= LIM) begin
         err_total++;
         conclude();
      end
   endtask : wait_core

   // =====================================================
   // scenarios
   task automatic t_power_ext;
      int n;
      i_sup.cold(1'b0, 16'h3C5A, 30000);
      tick();
      chk(pins(), 24'h1FB);
      i_sup.release_req();
      wait_core(n);
      chk(24'(n), 24'h5);
      chk(pins(), 24'h603);
      chk({8'h0, sys_config_q}, 24'h3C5A);
      chk(fetch_addr, 24'h0);
      chk(24'(fetch_start), 24'h1);
      tick();
      chk(24'(fetch_start), 24'h0);
      i_sup.wander();
      repeat (3) tick();
      chk({8'h0, sys_config_q}, 24'h3C5A);
   endtask : t_power_ext

   task automatic t_int_boot;
      int n;
      logic [15:0] prev;
      i_sup.cold(1'b1, 16'hC3A5, 13);
      i_sup.release_req();
      repeat (2) tick();
      chk({8'h0, flash_read_data_q}, 24'hFFFF);
      repeat (FL_CYC - 6) tick();
      chk({8'h0, flash_read_data_q}, 24'h9B);
      chk(pins(), 24'h1FB);
      wait_core(n);
      chk(24'(n >= FL_CYC - 36 && n <= FL_CYC - 30), 24'h1);
      chk(24'(flash_ready), 24'h1);
      chk(24'(fetch_start), 24'h1);
      chk({8'h0, sys_config_q}, 24'hC3A5);
      prev = flash_array_data;
      tick();
      chk({8'h0, flash_read_data_q}, {8'h0, prev});
   endtask : t_int_boot

   task automatic t_done_early;
      int n;
      i_sup.cold(1'b1, 16'h0F0F, 13);
      i_sup.release_req();
      repeat (6) tick();
      i_sup.done(1'b1);
      wait_core(n);
      chk(24'(n <= 8), 24'h1);
      i_sup.done(1'b0);
   endtask : t_done_early

   // warm request ignored until kind falls during it
   task automatic t_kind_late;
      int n;
      i_sup.warm();
      #1;
      chk(24'(core_reset_n), 24'h1);
      i_sup.kind_low();
      #1;
      chk(pins(), 24'h1FB);
      i_sup.release_req();
      wait_core(n);
      chk(24'(fetch_start), 24'h1);
   endtask : t_kind_late

   task automatic t_noclk;
      int n;
      @(posedge sys_clk);
      #5;
      clk_run = 1'b0;
      i_sup.drop_now();
      #100;
      chk(pins(), 24'h1FB);
      clk_run = 1'b1;
      i_sup.cold(1'b0, 16'h55AA, 13);
      i_sup.release_req();
      wait_core(n);
      chk(24'(n), 24'h5);
      chk({8'h0, sys_config_q}, 24'h55AA);
   endtask : t_noclk

   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_power_ext();
      t_int_boot();
      t_done_early();
      t_kind_late();
      t_noclk();
      conclude();
   end
endmodule : ars_sequencer_bench

// >>> ars_supervisor.sv
/*
 Reset supervisor and boot memory model facing the cold reset sequencer.
 Assumes sys_clk from the bench; pins change just after its rising edge, save in drop_now, which needs no edge.
*/
`timescale 1ns/1ps

module ars_supervisor (
   // clock
   input  wire logic  sys_clk,
   // reset pins
   output logic        reset_request_n,
   output logic        reset_kind_select,
   output logic        external_boot_select_n,
   output logic [15:0] configuration_port,
   // flash
   output logic        flash_init_done,
   output logic [15:0] flash_array_data
);
   // power up with both pins low
   initial begin
      reset_request_n = 1'b0;
      reset_kind_select = 1'b0;
      external_boot_select_n = 1'b0;
      configuration_port = 16'h0000;
      flash_init_done = 1'b0;
      flash_array_data = 16'h1357;
   end

   // array word moves every cycle so late reads show fresh data
   always @(posedge sys_clk) begin
      flash_array_data <= flash_array_data + 16'h0101;
   end

   // =====================================================
   // pin sequences
   // both low, config settled, long hold
   task automatic cold(input logic ext_n, input logic [15:0] cfg, input int cyc);
      @(posedge sys_clk);
      reset_request_n <= 1'b0;
      reset_kind_select <= 1'b0;
      external_boot_select_n <= ext_n;
      configuration_port <= cfg;
      repeat (cyc) @(posedge sys_clk);
   endtask : cold

   task automatic release_req;
      @(posedge sys_clk);
      reset_request_n <= 1'b1;
   endtask : release_req

   // config changes only once the device runs
   task automatic wander;
      @(posedge sys_clk);
      configuration_port <= ~configuration_port;
   endtask : wander

   // warm kind preferred by the system
   // warm request, pulse above 500 ns
   task automatic warm;
      @(posedge sys_clk);
      reset_kind_select <= 1'b1;
      reset_request_n <= 1'b0;
      repeat (13) @(posedge sys_clk);
   endtask : warm

   task automatic kind_low;
      @(posedge sys_clk);
      reset_kind_select <= 1'b0;
   endtask : kind_low

   // no clock edge to wait for here
   task automatic drop_now;
      reset_request_n = 1'b0;
      reset_kind_select = 1'b0;
   endtask : drop_now

   task automatic done(input logic v);
      @(posedge sys_clk);
      flash_init_done <= v;
   endtask : done
endmodule : ars_supervisor

// >>> ars_sync.sv
/*
 Two-flop synchroniser for a bundle of pin levels.
 Assumes each bit is a slow level; a word that changes is only read
 once it has settled for the whole reset phase.
*/
`timescale 1ns/1ps

module ars_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : ars_sync
